/* hw/pmseq_pkg.sv */
// package: constants and carriers for the power-monitor sequencer
// assumes a 10 MHz device clock and decoded register accesses from the serial interface
package pmseq_pkg;
  // ==========================================================
  // register map
  localparam logic [5:0] ADDR_MAIN = 6'h00;
  localparam logic [5:0] ADDR_SETUP = 6'h01;
  localparam logic [5:0] ADDR_CAL = 6'h02;
  localparam logic [5:0] ADDR_SHUNT = 6'h04;
  localparam logic [5:0] ADDR_BUS = 6'h05;
  localparam int MODE_LO = 12;
  localparam int BUS_CT_LO = 9;
  localparam int SH_CT_LO = 6;
  localparam int TMP_CT_LO = 3;
  localparam int AVG_LO = 0;
  localparam int RANGE_BIT = 4;
  localparam logic [15:0] SETUP_RST = 16'hfb68;
  localparam logic [14:0] CAL_RST = 15'h1000;
  localparam logic [3:0] MODE_OFF_A = 4'h0;
  localparam logic [3:0] MODE_OFF_B = 4'h8;
  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned CONV_US [8] = '{50, 84, 150, 280, 540, 1052, 2074, 4120};
  localparam int unsigned AVG_LOG2 [8] = '{0, 2, 4, 6, 7, 8, 9, 10};
  localparam int CUR_SHIFT_WIDE = 11;
  localparam int CUR_SHIFT_NARROW = 13;
  function automatic int unsigned us_to_cyc(input int unsigned us);
    return (us * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction
  localparam int unsigned CONV_CYC_DEF [8] = '{us_to_cyc(CONV_US[0]), us_to_cyc(CONV_US[1]),
    us_to_cyc(CONV_US[2]), us_to_cyc(CONV_US[3]), us_to_cyc(CONV_US[4]), us_to_cyc(CONV_US[5]),
    us_to_cyc(CONV_US[6]), us_to_cyc(CONV_US[7])};
  // ==========================================================
  // carriers
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [15:0] wdata;
  } pmseq_req_s;
  typedef struct packed {
    logic signed [15:0] bus;
    logic signed [15:0] shunt;
  } pmseq_samples_s;
  typedef enum logic [1:0] {
    PMS_IDLE = 2'b01,
    PMS_CONV = 2'b10
  } pmseq_phase_e;
  typedef struct packed {
    pmseq_phase_e phase;
    logic [15:0] setup;
    logic [14:0] cal;
    logic range;
    logic signed [15:0] shunt_res;
    logic signed [15:0] bus_res;
    logic signed [15:0] cur_res;
    logic [15:0] rdata;
    logic [1:0] chan;
    logic [15:0] timer;
    logic [10:0] rounds;
    logic signed [25:0] acc_bus;
    logic signed [25:0] acc_sh;
    logic done;
  } pmseq_state_s;
endpackage

/* hw/pmseq_core.sv */
// module: conversion sequencer, averaging and result registers
// assumes register accesses arrive decoded from the serial interface, one per cycle,
// and that the converter presents its latest bus and shunt samples as steady levels
//
// Overview of operation
// (R1) mode 0h or 8h, reset Fh, in bits 15-12 halts all conversions
// (R2) codes 1h-7h run one triggered pass over the inputs their low bits select
// (R3) code 9h converts bus, Ah shunt, repeating without further triggers
// (R4) reset code Fh converts bus, shunt and temperature repeatedly
// (R5) codes Bh-Eh use the same input bits as 3h-6h, repeating
// (R6) bus conversion time bits 11-9, reset 5h, from the eight-entry table
// (R7) shunt conversion time bits 8-6, reset 5h, same table
// (R8) temperature conversion time bits 5-3, reset 5h, same table
// (R9) averaging bits 2-0, reset 0h, counts 1 to 1024 for all inputs
// (R10) results stay unchanged until the whole averaging run completes
// (R11) calibration constant bits 14-0, reset 1000h, scales the current
// (R12) calibration constant also sets the current result's weight per count
// (R13) calibration bit 15 always reads zero
// (R14) shunt result is signed 16 bits, 5 or 1.25 microvolt per count
// (R15) bus result is signed 16 bits, never negative, 3.125 millivolt per count
// (R16) range bit 4 of main config picks 163.84 mV or 40.96 mV scale
`timescale 1ns/10ps
module pmseq_core
  import pmseq_pkg::*;
#(
  parameter int unsigned CONV_CYC [8] = CONV_CYC_DEF
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire pmseq_req_s req,
  input wire pmseq_samples_s samples,
  output logic [15:0] reg_rdata,
  output logic signed [15:0] current_result,
  output logic conv_busy,
  output logic conv_done,
  output logic [1:0] conv_channel
);
  // ==========================================================
  // parameter checks
  for (genvar g = 0; g < 8; g++) begin : g_chk
    if (CONV_CYC[g] < 1 || CONV_CYC[g] > 65535) begin : g_bad
      $error("conversion cycle count out of range");
    end
  end

  pmseq_state_s s;
  pmseq_state_s next_s;

  // ==========================================================
  // helpers
  function automatic logic [1:0] next_chan(input logic [2:0] act, input logic [2:0] from);
    logic [1:0] r;
    r = 2'd3;
    for (int i = 2; i >= 0; i--) begin
      if (act[i] && 3'(i) >= from) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] chan_cycles(input logic [15:0] setup, input logic [1:0] ch);
    logic [2:0] sel;
    sel = setup[TMP_CT_LO +: 3]; // R8
    if (ch == 2'd0) begin
      sel = setup[BUS_CT_LO +: 3]; // R6
    end else if (ch == 2'd1) begin
      sel = setup[SH_CT_LO +: 3]; // R7
    end
    return 16'(CONV_CYC[sel]);
  endfunction

  function automatic logic signed [15:0] scale_current(input logic signed [15:0] sh,
      input logic [14:0] cal, input logic range);
    logic signed [31:0] prod;
    prod = 32'(sh) * $signed({17'h0_0000, cal}); // R11
    prod = range ? (prod >>> CUR_SHIFT_NARROW) : (prod >>> CUR_SHIFT_WIDE); // R12 R16
    return prod[15:0];
  endfunction

  function automatic int unsigned max_cycles();
    int unsigned m;
    m = 0;
    for (int i = 0; i < 8; i++) begin
      if (CONV_CYC[i] > m) begin
        m = CONV_CYC[i];
      end
    end
    return m;
  endfunction
  localparam int unsigned CYC_MAX = max_cycles();

  // ==========================================================
  // sequencing and register access
  always_comb begin
    logic [3:0] mode;
    logic [2:0] act;
    logic [1:0] nxt;
    logic [3:0] lg;
    logic signed [25:0] acc_b;
    logic signed [25:0] acc_s;
    logic signed [25:0] avg_b;
    logic signed [25:0] avg_s;
    mode = s.setup[MODE_LO +: 4];
    act = mode[2:0];
    nxt = 2'd3;
    lg = 4'(AVG_LOG2[s.setup[AVG_LO +: 3]]); // R9
    acc_b = s.acc_bus;
    acc_s = s.acc_sh;
    avg_b = '0;
    avg_s = '0;
    next_s = s;
    next_s.done = 1'b0;
    if (req.rd) begin
      case (req.addr)
        ADDR_MAIN: next_s.rdata = 16'(s.range) << RANGE_BIT;
        ADDR_SETUP: next_s.rdata = s.setup;
        ADDR_CAL: next_s.rdata = {1'b0, s.cal}; // R13
        ADDR_SHUNT: next_s.rdata = s.shunt_res;
        ADDR_BUS: next_s.rdata = s.bus_res;
        default: next_s.rdata = '0;
      endcase
    end
    if (req.wr && req.addr == ADDR_SETUP) begin
      next_s.setup = req.wdata;
      next_s.rounds = '0;
      next_s.acc_bus = '0;
      next_s.acc_sh = '0;
      if (req.wdata[MODE_LO +: 3] != 3'd0) begin // R1
        next_s.phase = PMS_CONV; // R2 R3 R4 R5
        next_s.chan = next_chan(req.wdata[MODE_LO +: 3], 3'd0);
        next_s.timer = chan_cycles(req.wdata, next_s.chan);
      end else begin
        next_s.phase = PMS_IDLE; // R1
        next_s.timer = '0;
      end
    end else if (s.phase == PMS_CONV) begin
      if (s.timer > 16'd1) begin
        next_s.timer = s.timer - 16'd1;
      end else begin
        if (s.chan == 2'd0) begin
          acc_b = s.acc_bus + 26'(samples.bus);
        end else if (s.chan == 2'd1) begin
          acc_s = s.acc_sh + 26'(samples.shunt); // R14
        end
        next_s.acc_bus = acc_b;
        next_s.acc_sh = acc_s;
        nxt = next_chan(act, 3'(s.chan) + 3'd1);
        if (nxt != 2'd3) begin
          next_s.chan = nxt;
          next_s.timer = chan_cycles(s.setup, nxt);
        end else if (s.rounds + 11'd1 < (11'd1 << lg)) begin // R10
          next_s.rounds = s.rounds + 11'd1;
          next_s.chan = next_chan(act, 3'd0);
          next_s.timer = chan_cycles(s.setup, next_s.chan);
        end else begin
          avg_b = acc_b >>> lg;
          avg_s = acc_s >>> lg;
          if (act[0]) begin
            next_s.bus_res = avg_b[15] ? 16'h0000 : avg_b[15:0]; // R15
          end
          if (act[1]) begin
            next_s.shunt_res = avg_s[15:0]; // R10 R14
            next_s.cur_res = scale_current(avg_s[15:0], s.cal, s.range); // R11 R12
          end
          next_s.done = 1'b1;
          next_s.rounds = '0;
          next_s.acc_bus = '0;
          next_s.acc_sh = '0;
          if (mode[3]) begin
            next_s.chan = next_chan(act, 3'd0); // R3 R4 R5
            next_s.timer = chan_cycles(s.setup, next_s.chan);
          end else begin
            next_s.phase = PMS_IDLE; // R2
            next_s.timer = '0;
          end
        end
      end
    end
    if (req.wr && req.addr == ADDR_CAL) begin
      next_s.cal = req.wdata[14:0]; // R11
    end
    if (req.wr && req.addr == ADDR_MAIN) begin
      next_s.range = req.wdata[RANGE_BIT]; // R16
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s.phase <= PMS_CONV;
      s.setup <= SETUP_RST;
      s.cal <= CAL_RST;
      s.range <= 1'b0;
      s.shunt_res <= '0;
      s.bus_res <= '0;
      s.cur_res <= '0;
      s.rdata <= '0;
      s.chan <= 2'd0;
      s.timer <= 16'(CONV_CYC[SETUP_RST[BUS_CT_LO +: 3]]);
      s.rounds <= '0;
      s.acc_bus <= '0;
      s.acc_sh <= '0;
      s.done <= 1'b0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign current_result = s.cur_res;
  assign conv_busy = s.phase[1]; // one-hot conversion bit
  assign conv_done = s.done;
  assign conv_channel = s.chan;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence seq_start_write;
    ce && req.wr && req.addr == ADDR_SETUP && req.wdata[MODE_LO +: 3] != 3'd0;
  endsequence
  sequence seq_fresh_pass;
    conv_busy && s.rounds == 11'd0 && s.acc_bus == 26'sd0 && s.acc_sh == 26'sd0;
  endsequence
  sequence seq_stop_write;
    ce && req.wr && req.addr == ADDR_SETUP && req.wdata[MODE_LO +: 3] == 3'd0;
  endsequence
  sequence seq_setup_write;
    ce && req.wr && req.addr == ADDR_SETUP;
  endsequence
  sequence seq_counting;
    ce && conv_busy && s.timer > 16'd1 && !(req.wr && req.addr == ADDR_SETUP);
  endsequence
  sequence seq_last_tick;
    ce && conv_busy && s.timer == 16'd1 && !(req.wr && req.addr == ADDR_SETUP);
  endsequence
  sequence seq_read_at(logic [5:0] a);
    ce && req.rd && req.addr == a;
  endsequence

  chk_shutdown_idle: assert property (conv_busy |-> s.setup[MODE_LO +: 3] != 3'd0) // R1
    else $error("busy in shutdown mode");
  chk_write_starts: assert property (seq_start_write |=> seq_fresh_pass) // R2
    else $error("setup write did not start a fresh pass");
  chk_single_stops: assert property (conv_done && !s.setup[15] |-> !conv_busy) // R2
    else $error("single pass kept converting");
  chk_cont_repeats: assert property (conv_done && s.setup[15] |-> conv_busy) // R3
    else $error("continuous mode stopped");
  chk_chan_active: assert property (conv_busy |-> s.setup[MODE_LO + 32'(conv_channel)]) // R5
    else $error("inactive input converted");
  chk_timer_bound: assert property (conv_busy |-> s.timer >= 16'd1 && s.timer <= 16'(CYC_MAX)) // R6
    else $error("conversion timer out of range");
  chk_avg_hold: assert property ($changed(s.shunt_res) || $changed(s.bus_res) |-> conv_done) // R10
    else $error("result changed before averaging completed");
  chk_cal_reserved: assert property (ce && req.rd && req.addr == ADDR_CAL |=> reg_rdata[15] == 1'b0) // R13
    else $error("reserved calibration bit read as one");
  chk_bus_positive: assert property (s.bus_res[15] == 1'b0) // R15
    else $error("bus result negative");

  // ==========================================================
  // pass sequencing checks
  chk_stop_write: assert property (seq_stop_write |=> !conv_busy) // R1
    else $error("shutdown write left a pass running");
  chk_idle_still: assert property (!conv_busy && !(ce && req.wr && req.addr == ADDR_SETUP) |=> !conv_busy) // R2
    else $error("idle sequencer started without a setup write");
  chk_chan_valid: assert property (conv_busy |-> conv_channel != 2'd3) // R2
    else $error("busy with no input selected");
  chk_setup_store: assert property (seq_setup_write |=> s.setup == $past(req.wdata)) // R6 R7 R8 R9
    else $error("setup write not stored");
  chk_timer_count: assert property (seq_counting |=> s.timer == $past(s.timer) - 16'd1) // R6 R7 R8
    else $error("conversion timer did not count down");
  chk_tick_moves: assert property (seq_last_tick |=> // R9 R10
      conv_done || s.rounds != $past(s.rounds) || conv_channel != $past(conv_channel))
    else $error("conversion end did not advance the pass");

  // ==========================================================
  // register access checks
  chk_cal_store: assert property (ce && req.wr && req.addr == ADDR_CAL |=> s.cal == $past(req.wdata[14:0])) // R11
    else $error("calibration write not stored");
  chk_range_store: assert property (ce && req.wr && req.addr == ADDR_MAIN // R16
      |=> s.range == $past(req.wdata[RANGE_BIT]))
    else $error("range write not stored");
  chk_read_setup: assert property (seq_read_at(ADDR_SETUP) |=> reg_rdata == $past(s.setup)) // R6 R7 R8 R9
    else $error("setup read returned a wrong value");
  chk_read_cal: assert property (seq_read_at(ADDR_CAL) |=> reg_rdata[14:0] == $past(s.cal)) // R11
    else $error("calibration read returned a wrong value");
  chk_read_shunt: assert property (seq_read_at(ADDR_SHUNT) |=> reg_rdata == $past(s.shunt_res)) // R14
    else $error("shunt read returned a wrong value");
  chk_read_bus: assert property (seq_read_at(ADDR_BUS) |=> reg_rdata == $past(s.bus_res)) // R15
    else $error("bus read returned a wrong value");
  chk_main_reserved: assert property (seq_read_at(ADDR_MAIN) |=> // R16
      reg_rdata[15:5] == 11'h000 && reg_rdata[3:0] == 4'h0)
    else $error("reserved main config bits read as one");
  chk_rdata_hold: assert property (!(ce && req.rd) |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  // ==========================================================
  // result and enable checks
  chk_cur_update: assert property ($changed(current_result) |-> conv_done) // R12
    else $error("current changed outside a pass end");
  chk_ce_freeze: assert property (!ce |=> $stable(s))
    else $error("state moved while clock enable was low");
endmodule

/* verification/pmseq_adc_model.sv */
// model: converter front end presenting steady bus and shunt sample levels
// assumes the bench sets the levels between conversions
`timescale 1ns/10ps
module pmseq_adc_model
  import pmseq_pkg::*;
(
  input wire logic signed [15:0] bus_level,
  input wire logic signed [15:0] shunt_level,
  output pmseq_samples_s samples
);
  // ==========================================================
  // sample levels
  assign samples.bus = bus_level;
  assign samples.shunt = shunt_level;
endmodule

/* verification/test_power_monitor_adc_sequencer.sv */
// testbench: register access, mode sequencing, averaging and scaling checks
// assumes pmseq_core with short conversion times and a level-driven sample source
`timescale 1ns/10ps
module test_power_monitor_adc_sequencer
  import pmseq_pkg::*;
;
  // ==========================================================
  // signals
  localparam int unsigned CYC [8] = '{2, 3, 4, 5, 6, 7, 8, 9};
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  pmseq_req_s req = '0;
  logic signed [15:0] bus_lvl = 16'sh0000;
  logic signed [15:0] sh_lvl = 16'sh0000;
  pmseq_samples_s samples;
  logic [15:0] reg_rdata;
  logic signed [15:0] current_result;
  logic conv_busy;
  logic conv_done;
  logic [1:0] conv_channel;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  int n_cyc;
  logic [15:0] rd_val;
  always #50 clk = ~clk;
  pmseq_adc_model adc_u (.bus_level(bus_lvl), .shunt_level(sh_lvl), .samples(samples));
  pmseq_core #(.CONV_CYC(CYC)) dut_u (.clk(clk), .resetn(resetn), .ce(ce), .req(req), .samples(samples),
    .reg_rdata(reg_rdata), .current_result(current_result), .conv_busy(conv_busy), .conv_done(conv_done),
    .conv_channel(conv_channel));
  // ==========================================================
  // tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic reg_wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req.wr <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input string what, input logic [5:0] a, input logic [15:0] exp);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    check(what, reg_rdata, exp);
  endtask
  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (conv_done !== 1'b1 && n < 5000);
  endtask
  function automatic logic [15:0] cfg(input logic [3:0] m, input logic [2:0] sample_count_sel);
    return {m, 3'h1, 3'h2, 3'h6, sample_count_sel};
  endfunction
  function automatic logic [15:0] exp_time(input logic [3:0] m);
    return 16'(m[0] ? CYC[1] : 0) + 16'(m[1] ? CYC[2] : 0) + 16'(m[2] ? CYC[6] : 0);
  endfunction
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  // ==========================================================
  // tests
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd_chk("setup", ADDR_SETUP, 16'hfb68);
    rd_chk("cal", ADDR_CAL, 16'h1000);
    rd_chk("shunt", ADDR_SHUNT, 16'h0000);
    rd_chk("bus", ADDR_BUS, 16'h0000);
    check("busy", {15'h0, conv_busy}, 16'h0001);
    reg_wr(ADDR_CAL, 16'hffff);
    rd_chk("cal", ADDR_CAL, 16'h7fff);
    reg_wr(ADDR_CAL, 16'h1000);
    for (int m = 0; m < 16; m += 8) begin
      reg_wr(ADDR_SETUP, cfg(m[3:0], 3'h0));
      check("stop", {15'h0, conv_busy}, 16'h0000);
      repeat (20) @(posedge clk);
      #1;
      check("still", {14'h0, conv_busy, conv_done}, 16'h0000);
    end
    @(posedge clk);
    bus_lvl <= 16'sh1234;
    sh_lvl <= -16'sd8;
    for (int m = 1; m < 8; m++) begin
      reg_wr(ADDR_SETUP, cfg(m[3:0], 3'h0));
      check("chan", {14'h0, conv_channel}, 16'(m[0] ? 0 : (m[1] ? 1 : 2)));
      wait_done(n_cyc);
      check("pass time", n_cyc[15:0], exp_time(m[3:0]));
      check("idle", {15'h0, conv_busy}, 16'h0000);
    end
    rd_chk("bus", ADDR_BUS, 16'h1234);
    rd_chk("shunt", ADDR_SHUNT, 16'hfff8);
    check("current", current_result, 16'hfff0);
    reg_wr(ADDR_MAIN, 16'h0010);
    rd_chk("range", ADDR_MAIN, 16'h0010);
    reg_wr(ADDR_SETUP, cfg(4'h2, 3'h0));
    wait_done(n_cyc);
    check("current", current_result, 16'hfffc);
    @(posedge clk);
    bus_lvl <= -16'sd5;
    sh_lvl <= 16'sh0064;
    reg_wr(ADDR_SETUP, cfg(4'h3, 3'h1));
    wait_done(n_cyc);
    check("avg time", n_cyc[15:0], 16'h001c);
    rd_chk("bus", ADDR_BUS, 16'h0000);
    rd_chk("shunt", ADDR_SHUNT, 16'h0064);
    @(posedge clk);
    sh_lvl <= 16'sh0020;
    reg_wr(ADDR_SETUP, cfg(4'h2, 3'h1));
    repeat (5) @(posedge clk);
    rd_chk("held", ADDR_SHUNT, 16'h0064);
    wait_done(n_cyc);
    rd_chk("shunt", ADDR_SHUNT, 16'h0020);
    for (int a = 2; a < 8; a++) begin
      reg_wr(ADDR_SETUP, cfg(4'h2, a[2:0]));
      wait_done(n_cyc);
      check("avg count", n_cyc[15:0], 16'(CYC[2] << AVG_LOG2[a]));
    end
    reg_wr(ADDR_SETUP, cfg(4'h2, 3'h0));
    @(posedge clk);
    ce <= 1'b0;
    repeat (10) @(posedge clk);
    ce <= 1'b1;
    wait_done(n_cyc);
    check("frozen", n_cyc[15:0], 16'(CYC[2] - 1));
    for (int m = 9; m < 16; m++) begin
      reg_wr(ADDR_SETUP, cfg(m[3:0], 3'h0));
      wait_done(n_cyc);
      check("first", n_cyc[15:0], exp_time(m[3:0]));
      wait_done(n_cyc);
      check("again", {14'h0, conv_busy, conv_done}, 16'h0003);
    end
    stop_test();
  end
endmodule
